// ===== i2c_slave_consts.svh
// constants for the two-wire slave engine
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH
`define MODE_TENBIT_BIT 0
`define MODE_SSINT_BIT 1
`define RW_BIT 0
`define HI_PREFIX_LSB 3
`define HI_A98_MSB 2
`define HI_A98_LSB 1
`define TEN_HI_PREFIX 5'h1e
`define BYTE_BITS 4'h8
`define LAST_TX_BIT 4'h7
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define BYTE_ZERO 8'h00
`define OWN_ADDR_RESET 8'h00
`endif

// ===== i2c_slave_pkg.sv
// types shared by the two-wire slave engine
package i2c_slave_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ADDR_LO = 3'h2,
      ST_RX = 3'h3,
      ST_ACK = 3'h4,
      ST_TX = 3'h5,
      ST_TXACK = 3'h6
   } slave_state_t;
endpackage : i2c_slave_pkg

// ===== pin_sampler.sv
// three-stage sampler with agreement filter for bus pins
module pin_sampler #(
   parameter int WIDTH = 2
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] pins_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] level_ff;
   wire [WIDTH-1:0] agree = ~(s2_ff ^ s3_ff);
   wire [WIDTH-1:0] nxt_level = (s2_ff & agree) | (level_ff & ~agree);

   if (WIDTH < 1)
   begin : g_bad_width
      $error("pin_sampler needs at least one pin");
   end

   // idle bus reads high, so reset to ones
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         s1_ff <= '1;
         s2_ff <= '1;
         s3_ff <= '1;
         level_ff <= '1;
      end
      else
      begin
         s1_ff <= pins_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         level_ff <= nxt_level;
      end
   end

   assign level_out = level_ff;
endmodule : pin_sampler

// ===== i2c_slave_engine.sv
// two-wire bus slave engine: addressing, receive, transmit, stretching
`include "i2c_slave_consts.svh"
module i2c_slave_engine
   import i2c_slave_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [1:0] port_mode_select_in,
   input wire logic stretch_enable_in,
   input wire logic addr_hold_enable_in,
   input wire logic data_hold_enable_in,
   input wire logic ack_value_to_send_in,
   input wire logic buffer_overwrite_enable_in,
   input wire logic slave_collision_detect_enable_in,
   input wire logic own_address_wr_in,
   input wire logic [7:0] own_address_data_in,
   input wire logic buffer_wr_in,
   input wire logic [7:0] buffer_wr_data_in,
   input wire logic buffer_rd_in,
   input wire logic flag_clear_in,
   input wire logic overflow_clear_in,
   input wire logic collision_clear_in,
   input wire logic clock_release_set_in,
   output logic scl_out,
   output logic scl_oe_out,
   output logic sda_out,
   output logic sda_oe_out,
   output logic [7:0] data_buffer_out,
   output logic [7:0] own_address_out,
   output logic buffer_full_out,
   output logic receive_overflow_out,
   output logic serial_event_flag_out,
   output logic addr_reload_request_out,
   output logic clock_release_out,
   output logic ack_time_flag_out,
   output logic ack_received_out,
   output logic read_write_out,
   output logic data_not_addr_out,
   output logic begin_detected_out,
   output logic halt_detected_out,
   output logic bus_collision_flag_out
);
   slave_state_t state_ff, nxt_state, after_ff, nxt_after;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] shift_ff, nxt_shift, buf_ff, nxt_buf, own_ff, nxt_own;
   logic bf_ff, nxt_bf, ov_ff, nxt_ov, flag_ff, nxt_flag, ua_ff, nxt_ua;
   logic ckp_ff, nxt_ckp, ack_time_flag_ff, nxt_ack_time_flag, ack_received_ff, nxt_ack_received;
   logic rw_ff, nxt_rw, da_ff, nxt_da, start_ff, nxt_start, stop_ff, nxt_stop;
   logic bcl_ff, nxt_bcl, prior_ff, nxt_prior, soft_ff, nxt_soft;
   logic hwack_ff, nxt_hwack, setua_ff, nxt_setua, read_ff, nxt_read;
   logic hold_ff, sda_oe_ff, scl_prev_ff, sda_prev_ff, zero_ff;
   logic [1:0] level;

   function automatic logic hi_match(input logic [7:0] b, input logic [7:0] own);
      hi_match = (b[7:`HI_PREFIX_LSB] == `TEN_HI_PREFIX) &&
                 (b[`HI_A98_MSB:`HI_A98_LSB] == own[`HI_A98_MSB:`HI_A98_LSB]);
   endfunction : hi_match

   pin_sampler #(
      .WIDTH(2)
   ) u_sampler (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .pins_in({scl_in, sda_in}),
      .level_out(level)
   );

   wire scl_lvl = level[1];
   wire sda_lvl = level[0];
   wire scl_rise = scl_lvl & ~scl_prev_ff;
   wire scl_fall = ~scl_lvl & scl_prev_ff;
   wire start_det = scl_lvl & scl_prev_ff & sda_prev_ff & ~sda_lvl;
   wire stop_det = scl_lvl & scl_prev_ff & ~sda_prev_ff & sda_lvl;
   wire tenbit = port_mode_select_in[`MODE_TENBIT_BIT];
   wire ss_int = port_mode_select_in[`MODE_SSINT_BIT];
   wire rw_bit = shift_ff[`RW_BIT];
   wire m7 = shift_ff[7:1] == own_ff[7:1];
   wire m_hi = hi_match(shift_ff, own_ff);
   // reads only after a full write match
   wire m10 = m_hi & (~rw_bit | prior_ff);
   wire m_lo = shift_ff == own_ff;
   wire addr_hit = tenbit ? m10 : m7;
   wire is_addr = state_ff != ST_RX;
   wire busy = bf_ff | ov_ff;
   wire hw_ok = ~busy | buffer_overwrite_enable_in;
   wire soft_sel = is_addr ? addr_hold_enable_in : data_hold_enable_in;
   wire byte_done = scl_fall & (cnt_ff == `BYTE_BITS);
   wire ack_now = soft_ff ? ~ack_value_to_send_in : hwack_ff;
   // drive low only for ack or a zero bit
   wire nxt_sda_oe = (state_ff == ST_ACK & ack_now) |
                     (state_ff == ST_TX & bf_ff & ~shift_ff[7]);
   wire hold_req = ~ckp_ff | ua_ff;
   // grab SCL only once it is already low
   wire nxt_hold = hold_req & (hold_ff | ~scl_lvl);
   wire collide = scl_rise & ~sda_oe_ff & ~sda_lvl;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_after = after_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_buf = buf_ff;
      nxt_own = own_ff;
      nxt_bf = bf_ff;
      nxt_ov = ov_ff;
      nxt_flag = flag_ff;
      nxt_ua = ua_ff;
      nxt_ckp = ckp_ff;
      nxt_ack_time_flag = ack_time_flag_ff;
      nxt_ack_received = ack_received_ff;
      nxt_rw = rw_ff;
      nxt_da = da_ff;
      nxt_start = start_ff;
      nxt_stop = stop_ff;
      nxt_bcl = bcl_ff;
      nxt_prior = prior_ff;
      nxt_soft = soft_ff;
      nxt_hwack = hwack_ff;
      nxt_setua = setua_ff;
      nxt_read = read_ff;
      // software side first so hardware events below win
      if (buffer_rd_in)
         nxt_bf = 1'b0;
      if (overflow_clear_in)
         nxt_ov = 1'b0;
      if (flag_clear_in)
         nxt_flag = 1'b0;
      if (collision_clear_in)
         nxt_bcl = 1'b0;
      if (clock_release_set_in)
         nxt_ckp = 1'b1;
      if (own_address_wr_in)
      begin
         nxt_own = own_address_data_in;
         nxt_ua = 1'b0;
      end
      // buffer write in ST_TX also loads the shifter
      if (buffer_wr_in)
      begin
         nxt_buf = buffer_wr_data_in;
         nxt_bf = 1'b1;
         if (state_ff == ST_TX)
            nxt_shift = buffer_wr_data_in;
      end
      if (start_det)
      begin
         if (ss_int)
            nxt_flag = 1'b1;
         nxt_state = ST_ADDR;
         nxt_cnt = `CNT_ZERO;
         nxt_start = 1'b1;
         nxt_stop = 1'b0;
         nxt_ack_time_flag = 1'b0;
      end
      else if (stop_det)
      begin
         if (ss_int)
            nxt_flag = 1'b1;
         nxt_state = ST_IDLE;
         nxt_start = 1'b0;
         nxt_stop = 1'b1;
         nxt_prior = 1'b0;
         nxt_ack_time_flag = 1'b0;
      end
      else
      begin
         case (state_ff)
            ST_ADDR, ST_ADDR_LO, ST_RX:
            begin
               if (scl_rise && cnt_ff != `BYTE_BITS)
               begin
                  nxt_shift = {shift_ff[6:0], sda_lvl};
                  nxt_cnt = cnt_ff + `CNT_ONE;
               end
               if (byte_done)
               begin
                  nxt_state = ST_ACK;
                  nxt_after = ST_RX;
                  nxt_read = 1'b0;
                  nxt_setua = 1'b0;
                  nxt_soft = 1'b0;
                  nxt_hwack = 1'b0;
                  // miss on first byte goes idle silently
                  if (state_ff == ST_ADDR && !addr_hit)
                  begin
                     nxt_state = ST_IDLE;
                     nxt_prior = 1'b0;
                  end
                  else if (state_ff == ST_ADDR_LO && !m_lo)
                  begin
                     nxt_setua = 1'b1;
                     nxt_after = ST_IDLE;
                  end
                  else
                  begin
                     nxt_hwack = hw_ok;
                     nxt_da = ~is_addr;
                     if (hw_ok)
                     begin
                        nxt_buf = shift_ff;
                        nxt_bf = 1'b1;
                     end
                     if (!is_addr && bf_ff)
                        nxt_ov = 1'b1;
                     if (soft_sel)
                     begin
                        nxt_soft = 1'b1;
                        nxt_flag = 1'b1;
                        nxt_ckp = 1'b0;
                        nxt_ack_time_flag = 1'b1;
                     end
                     if (state_ff == ST_ADDR)
                     begin
                        nxt_rw = rw_bit;
                        // high byte write leads to reload
                        if (tenbit && !rw_bit)
                        begin
                           nxt_setua = 1'b1;
                           nxt_after = ST_ADDR_LO;
                           nxt_prior = 1'b0;
                        end
                        if (rw_bit)
                        begin
                           nxt_read = 1'b1;
                           nxt_after = ST_TX;
                        end
                     end
                     else if (state_ff == ST_ADDR_LO)
                     begin
                        nxt_setua = 1'b1;
                        nxt_prior = 1'b1;
                     end
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  nxt_ack_time_flag = 1'b0;
                  if (setua_ff)
                  begin
                     nxt_ua = 1'b1;
                     nxt_flag = 1'b1;
                  end
                  if (ack_now)
                  begin
                     nxt_flag = 1'b1;
                     nxt_state = after_ff;
                     nxt_cnt = `CNT_ZERO;
                     if (read_ff)
                        nxt_ckp = 1'b0;
                     else if (stretch_enable_in && !setua_ff)
                        nxt_ckp = 1'b0;
                  end
                  else
                     nxt_state = ST_IDLE;
               end
            end
            ST_TX:
            begin
               if (collide && slave_collision_detect_enable_in)
               begin
                  nxt_bcl = 1'b1;
                  nxt_state = ST_IDLE;
               end
               // next bit after each falling edge
               else if (scl_fall)
               begin
                  nxt_shift = {shift_ff[6:0], 1'b1};
                  nxt_cnt = cnt_ff + `CNT_ONE;
                  if (cnt_ff == `LAST_TX_BIT)
                  begin
                     nxt_state = ST_TXACK;
                     nxt_bf = 1'b0;
                  end
               end
            end
            ST_TXACK:
            begin
               if (scl_rise)
                  nxt_ack_received = sda_lvl;
               if (scl_fall)
               begin
                  nxt_flag = 1'b1;
                  nxt_cnt = `CNT_ZERO;
                  if (ack_received_ff)
                     nxt_state = ST_IDLE;
                  else
                  begin
                     nxt_state = ST_TX;
                     nxt_ckp = 1'b0;
                  end
               end
            end
            default:
            begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         state_ff <= ST_IDLE;
         after_ff <= ST_IDLE;
         cnt_ff <= `CNT_ZERO;
         shift_ff <= `BYTE_ZERO;
         buf_ff <= `BYTE_ZERO;
         own_ff <= `OWN_ADDR_RESET;
         {bf_ff, ov_ff, flag_ff, ua_ff, ack_time_flag_ff, ack_received_ff} <= '0;
         {rw_ff, da_ff, start_ff, stop_ff, bcl_ff, prior_ff} <= '0;
         {soft_ff, hwack_ff, setua_ff, read_ff, hold_ff, sda_oe_ff} <= '0;
         ckp_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         zero_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         after_ff <= nxt_after;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         buf_ff <= nxt_buf;
         own_ff <= nxt_own;
         {bf_ff, ov_ff, flag_ff, ua_ff} <= {nxt_bf, nxt_ov, nxt_flag, nxt_ua};
         {ack_time_flag_ff, ack_received_ff, rw_ff, da_ff} <= {nxt_ack_time_flag, nxt_ack_received, nxt_rw, nxt_da};
         {start_ff, stop_ff, bcl_ff, prior_ff} <= {nxt_start, nxt_stop, nxt_bcl, nxt_prior};
         {soft_ff, hwack_ff, setua_ff, read_ff} <= {nxt_soft, nxt_hwack, nxt_setua, nxt_read};
         ckp_ff <= nxt_ckp;
         hold_ff <= nxt_hold;
         sda_oe_ff <= nxt_sda_oe;
         scl_prev_ff <= scl_lvl;
         sda_prev_ff <= sda_lvl;
         // open-drain: the driven level is always low
         zero_ff <= 1'b0;
      end
   end

   assign scl_out = zero_ff;
   assign sda_out = zero_ff;
   assign scl_oe_out = hold_ff;
   assign sda_oe_out = sda_oe_ff;
   assign data_buffer_out = buf_ff;
   assign own_address_out = own_ff;
   assign buffer_full_out = bf_ff;
   assign receive_overflow_out = ov_ff;
   assign serial_event_flag_out = flag_ff;
   assign addr_reload_request_out = ua_ff;
   assign clock_release_out = ckp_ff;
   assign ack_time_flag_out = ack_time_flag_ff;
   assign ack_received_out = ack_received_ff;
   assign read_write_out = rw_ff;
   assign data_not_addr_out = da_ff;
   assign begin_detected_out = start_ff;
   assign halt_detected_out = stop_ff;
   assign bus_collision_flag_out = bcl_ff;
endmodule : i2c_slave_engine

// ===== i2c_slave_engine_props.sv
// assertion checker for the two-wire slave engine ports
module i2c_slave_engine_props (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic addr_hold_enable_in,
   input wire logic data_hold_enable_in,
   input wire logic slave_collision_detect_enable_in,
   input wire logic own_address_wr_in,
   input wire logic buffer_wr_in,
   input wire logic [7:0] buffer_wr_data_in,
   input wire logic flag_clear_in,
   input wire logic scl_out,
   input wire logic scl_oe_out,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [7:0] data_buffer_out,
   input wire logic buffer_full_out,
   input wire logic serial_event_flag_out,
   input wire logic addr_reload_request_out,
   input wire logic clock_release_out,
   input wire logic ack_time_flag_out,
   input wire logic halt_detected_out,
   input wire logic bus_collision_flag_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   // wire low while a hold is pending
   sequence s_held;
      !clock_release_out && !scl_in;
   endsequence
   sequence s_reload;
      addr_reload_request_out && !scl_in;
   endsequence
   AST_RELEASE_FREES: assert property ($rose(clock_release_out) && !addr_reload_request_out
      |-> ##[0:3] !scl_oe_out) else $error("clock held after release");
   AST_HOLD_WHEN_LOW: assert property (s_held [*8] |-> scl_oe_out)
      else $error("clock not held");
   AST_RELOAD_HOLDS: assert property (s_reload [*8] |-> scl_oe_out)
      else $error("clock not held on reload");
   AST_WR_CLEARS_RELOAD: assert property (own_address_wr_in |=> !addr_reload_request_out)
      else $error("reload request kept");
   AST_OUT_ZERO: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   AST_FLAG_STICKY: assert property (serial_event_flag_out && !flag_clear_in
      |=> serial_event_flag_out) else $error("event flag dropped");
   AST_BUF_LOAD: assert property (buffer_wr_in |=> buffer_full_out
      && data_buffer_out == $past(buffer_wr_data_in)) else $error("buffer load");
   AST_ACK_TIME_FLAG_MODE: assert property ($rose(ack_time_flag_out)
      |-> $past(addr_hold_enable_in || data_hold_enable_in))
      else $error("ack time outside hold");
   AST_SDA_IDLE: assert property (sda_oe_out |-> !halt_detected_out)
      else $error("data pulled on idle bus");
   AST_COLL_EN: assert property ($rose(bus_collision_flag_out)
      |-> $past(slave_collision_detect_enable_in)) else $error("collision disabled");
endmodule : i2c_slave_engine_props
bind i2c_slave_engine i2c_slave_engine_props chk (.sys_clk_in, .rst_in, .scl_in,
   .addr_hold_enable_in, .data_hold_enable_in, .slave_collision_detect_enable_in,
   .own_address_wr_in, .buffer_wr_in, .buffer_wr_data_in, .flag_clear_in, .scl_out,
   .scl_oe_out, .sda_out, .sda_oe_out, .data_buffer_out, .buffer_full_out,
   .serial_event_flag_out, .addr_reload_request_out, .clock_release_out,
   .ack_time_flag_out, .halt_detected_out, .bus_collision_flag_out);

// ===== i2c_bus_master.sv
// behavioural bus master pulling the clock and data wires low
module i2c_bus_master (
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_low_out,
   output logic sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   // slave may stretch; bounded so a stuck hold cannot hang
   task automatic rise_wait();
      int n = 0;
      scl_low_out = 1'b0;
      while (scl_in !== 1'b1 && n < 4000)
      begin
         #5;
         n++;
      end
   endtask : rise_wait
   task automatic xfer_bit(input logic tx, output logic rx);
      sda_low_out = ~tx;
      #20;
      rise_wait();
      #20;
      rx = sda_in;
      #20;
      scl_low_out = 1'b1;
      #20;
   endtask : xfer_bit
   // start or restart from low clock
   task automatic start();
      sda_low_out = 1'b0;
      #20;
      rise_wait();
      #20;
      sda_low_out = 1'b1;
      #40;
      scl_low_out = 1'b1;
      #20;
   endtask : start
   task automatic stop();
      sda_low_out = 1'b1;
      #20;
      rise_wait();
      #20;
      sda_low_out = 1'b0;
      #40;
   endtask : stop
   task automatic send8(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         xfer_bit(b[i], r);
   endtask : send8
   task automatic recv8(output logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         xfer_bit(1'b1, b[i]);
   endtask : recv8
endmodule : i2c_bus_master

// ===== i2c_slave_engine_tb.sv
// self-checking bench for the two-wire slave engine
module i2c_slave_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] P_OWN = 7'h01, P_BWR = 7'h02, P_BRD = 7'h04, P_FCL = 7'h08;
   localparam logic [6:0] P_CLR = 7'h30, P_REL = 7'h40;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [1:0] mode = 2'h0;
   logic stretch = 1'b0, ahold = 1'b0, dhold = 1'b0, ackv = 1'b0;
   logic [6:0] pls = 7'h00;
   logic [7:0] pdata = 8'h00;
   logic m_scl_low, m_sda_low, scl_oe_out, sda_oe_out, buffer_full_out, receive_overflow_out;
   logic serial_event_flag_out, addr_reload_request_out, clock_release_out, ack_time_flag_out;
   logic ack_received_out, read_write_out, data_not_addr_out, begin_detected_out;
   logic halt_detected_out, bus_collision_flag_out;
   logic coll_en = 1'b0;
   logic [7:0] data_buffer_out, own_address_out;
   // open-drain wires with pull-ups
   wire scl_w = ~(scl_oe_out | m_scl_low);
   wire sda_w = ~(sda_oe_out | m_sda_low);
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   i2c_slave_engine dut (.sys_clk_in, .rst_in, .scl_in(scl_w), .sda_in(sda_w),
      .port_mode_select_in(mode), .stretch_enable_in(stretch), .addr_hold_enable_in(ahold),
      .data_hold_enable_in(dhold), .ack_value_to_send_in(ackv),
      .buffer_overwrite_enable_in(1'b0), .slave_collision_detect_enable_in(coll_en),
      .own_address_wr_in(pls[0]), .own_address_data_in(pdata), .buffer_wr_in(pls[1]),
      .buffer_wr_data_in(pdata), .buffer_rd_in(pls[2]), .flag_clear_in(pls[3]),
      .overflow_clear_in(pls[4]), .collision_clear_in(pls[5]), .clock_release_set_in(pls[6]),
      .scl_out(), .scl_oe_out, .sda_out(), .sda_oe_out, .data_buffer_out,
      .own_address_out, .buffer_full_out, .receive_overflow_out, .serial_event_flag_out,
      .addr_reload_request_out, .clock_release_out, .ack_time_flag_out, .ack_received_out,
      .read_write_out, .data_not_addr_out, .begin_detected_out, .halt_detected_out,
      .bus_collision_flag_out);
   i2c_bus_master master (.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl_low),
      .sda_low_out(m_sda_low));
   initial
      forever #2.5 sys_clk_in = ~sys_clk_in;
   task end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   // generous ceiling: the whole run needs well under a tenth of it
   always @(posedge sys_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         fail_count++;
         end_sim();
      end
   end
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : wt
   task pulse(input logic [6:0] p, input logic [7:0] d);
      @(posedge sys_clk_in);
      pls <= p;
      pdata <= d;
      @(posedge sys_clk_in);
      pls <= 7'h00;
      wt(4);
   endtask : pulse
   task wbyte(input logic [7:0] b, input logic exp_ack);
      logic a;
      master.send8(b);
      master.xfer_bit(1'b1, a);
      wt(10);
      chk("ack bit", {7'h00, a}, {7'h00, exp_ack});
   endtask : wbyte
   task rbyte(input logic [7:0] exp, input logic nk);
      logic [7:0] b;
      logic a;
      master.recv8(b);
      chk("sent byte", b, exp);
      master.xfer_bit(nk, a);
      wt(10);
      chk("master ack", ack_received_out, nk);
      chk("event flag", serial_event_flag_out, 1'b1);
   endtask : rbyte
   task fin(input string name);
      master.stop();
      wt(10);
      $display("test %s done", name);
   endtask : fin
   task t_write7();
      mode <= 2'h2;
      stretch <= 1'b1;
      // register holds the address as it appears on the bus
      pulse(P_OWN, 8'h84);
      chk("own address", own_address_out, 8'h84);
      master.start();
      wt(10);
      chk("start seen", begin_detected_out, 1'b1);
      chk("start flag", serial_event_flag_out, 1'b1);
      pulse(P_FCL, 8'h00);
      wbyte(8'h84, 1'b0);
      chk("address buffered", data_buffer_out, 8'h84);
      chk("write dir", read_write_out, 1'b0);
      chk("byte flag", serial_event_flag_out, 1'b1);
      chk("stretch release", clock_release_out, 1'b0);
      chk("stretch pin", scl_oe_out, 1'b1);
      pulse(P_FCL | P_BRD | P_REL, 8'h00);
      wbyte(8'h5a, 1'b0);
      chk("data byte", data_buffer_out, 8'h5a);
      chk("data kind", data_not_addr_out, 1'b1);
      pulse(P_FCL | P_REL, 8'h00);
      wbyte(8'h33, 1'b1);
      chk("overflow", receive_overflow_out, 1'b1);
      pulse(P_FCL | P_BRD | P_REL | P_CLR, 8'h00);
      fin("write7");
      chk("stop seen", halt_detected_out, 1'b1);
      chk("stop flag", serial_event_flag_out, 1'b1);
      pulse(P_FCL, 8'h00);
   endtask : t_write7
   task t_miss();
      mode <= 2'h0;
      stretch <= 1'b0;
      master.start();
      wbyte(8'h90, 1'b1);
      chk("miss flag", serial_event_flag_out, 1'b0);
      chk("miss buffer", data_buffer_out, 8'h5a);
      fin("miss");
   endtask : t_miss
   task t_read7();
      master.start();
      wbyte(8'h85, 1'b0);
      chk("read dir", read_write_out, 1'b1);
      chk("read hold", clock_release_out, 1'b0);
      chk("read pin", scl_oe_out, 1'b1);
      pulse(P_FCL | P_BRD, 8'h00);
      pulse(P_BWR, 8'ha5);
      pulse(P_REL, 8'h00);
      rbyte(8'ha5, 1'b0);
      chk("held after ack", clock_release_out, 1'b0);
      pulse(P_FCL, 8'h00);
      pulse(P_BWR, 8'h3c);
      pulse(P_REL, 8'h00);
      rbyte(8'h3c, 1'b1);
      chk("freed after nack", scl_oe_out, 1'b0);
      fin("read7");
   endtask : t_read7
   task t_hold();
      logic a;
      ahold <= 1'b1;
      dhold <= 1'b1;
      pulse(P_FCL, 8'h00);
      master.start();
      master.send8(8'h84);
      wt(10);
      chk("eighth flag", serial_event_flag_out, 1'b1);
      chk("eighth release", clock_release_out, 1'b0);
      chk("ack time", ack_time_flag_out, 1'b1);
      pulse(P_FCL | P_BRD | P_REL, 8'h00);
      master.xfer_bit(1'b1, a);
      wt(10);
      chk("soft ack", {7'h00, a}, 8'h00);
      chk("ninth flag", serial_event_flag_out, 1'b1);
      chk("ack time end", ack_time_flag_out, 1'b0);
      pulse(P_FCL, 8'h00);
      master.send8(8'h11);
      wt(10);
      ackv <= 1'b1;
      pulse(P_FCL | P_BRD | P_REL, 8'h00);
      master.xfer_bit(1'b1, a);
      wt(10);
      chk("soft nack", {7'h00, a}, 8'h01);
      chk("no flag on nack", serial_event_flag_out, 1'b0);
      fin("hold");
      ahold <= 1'b0;
      dhold <= 1'b0;
      ackv <= 1'b0;
   endtask : t_hold
   task t_ten();
      mode <= 2'h1;
      pulse(P_OWN | P_FCL, 8'h06);
      master.start();
      wbyte(8'hf6, 1'b0);
      chk("reload set", addr_reload_request_out, 1'b1);
      chk("reload pin", scl_oe_out, 1'b1);
      chk("reload release", clock_release_out, 1'b1);
      pulse(P_OWN | P_FCL | P_BRD, 8'h5c);
      chk("reload clear", addr_reload_request_out, 1'b0);
      chk("reload freed", scl_oe_out, 1'b0);
      wbyte(8'h5c, 1'b0);
      chk("low reload", addr_reload_request_out, 1'b1);
      pulse(P_OWN | P_FCL | P_BRD, 8'h06);
      master.start();
      wbyte(8'hf7, 1'b0);
      chk("ten read dir", read_write_out, 1'b1);
      pulse(P_FCL | P_BRD, 8'h00);
      pulse(P_BWR, 8'h96);
      pulse(P_REL, 8'h00);
      rbyte(8'h96, 1'b1);
      fin("ten");
      mode <= 2'h3;
      pulse(P_FCL, 8'h00);
      master.start();
      wbyte(8'hf6, 1'b0);
      pulse(P_OWN | P_FCL | P_BRD, 8'h77);
      wbyte(8'h5c, 1'b1);
      chk("miss flag", serial_event_flag_out, 1'b1);
      chk("miss reload", addr_reload_request_out, 1'b1);
      chk("miss hold", scl_oe_out, 1'b1);
      pulse(P_OWN | P_FCL, 8'h06);
      fin("ten miss");
   endtask : t_ten
   task t_coll();
      logic a;
      mode <= 2'h0;
      pulse(P_OWN | P_FCL, 8'h84);
      master.start();
      wbyte(8'h85, 1'b0);
      pulse(P_FCL | P_BRD, 8'h00);
      pulse(P_BWR, 8'hff);
      pulse(P_REL, 8'h00);
      // master pulls a one low: ignored while detection is off
      master.xfer_bit(1'b0, a);
      wt(10);
      chk("no collision", bus_collision_flag_out, 1'b0);
      coll_en <= 1'b1;
      master.xfer_bit(1'b0, a);
      wt(10);
      chk("collision", bus_collision_flag_out, 1'b1);
      chk("collision release", sda_oe_out, 1'b0);
      fin("collision");
   endtask : t_coll
   initial
   begin
      repeat (20) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      wt(4);
      t_write7();
      t_miss();
      t_read7();
      t_hold();
      t_ten();
      t_coll();
      end_sim();
   end
endmodule : i2c_slave_engine_tb
